// *** logic/cod_defines.vh ***
// Constants for the coprocessor opcode decoder
// Contract
// - Coprocessor rt with bits 20:19 zero: 0-3 are the four condition branches; rest reserved.
// - System coprocessor functions: entry read, write indexed, write random, probe, returns, wait.
// - Unassigned system coprocessor functions act as no-operation, never reserved-instruction.
// - Multiply-accumulate function 0 signed, 1 unsigned; the other 62 codes reserved.
// - Reserved encodings of primary, special, rt and multiply tables raise reserved-instruction.
// - Class opcodes are never executed; a further field is decoded through its table.
// - Coprocessor opcodes raise coprocessor-unusable when that coprocessor is not accessible.
// - Coprocessor 3 opcode accepted only with the branch sub-operation; otherwise reserved.
// - Doubleword instructions only in kernel or 64-bit user/supervisor; else reserved.
// - Floating-point instructions are coprocessor unit 1 instructions.
// - Classify as immediate (loads/stores), register (FP operations) or branch/move group.
// - FP operation with reserved or unsupported format raises unimplemented-instruction.
// - Divide and square root valid for single and double, reserved for word and longword.
// - Round, truncate, ceiling, floor conversions valid for single and double sources.
// - Predicate and complement share a code; branch true/false selects it or its negation.
// - Code bits: 0 unordered, 1 equal, 2 less; codes 8-15 flag invalid when unordered.
// - Format field: 16 single, 17 double, 20 word, 21 longword; others reserved.
`ifndef COD_DEFINES_VH
`define COD_DEFINES_VH

`define COD_REG_CTRL 4'h0
`define COD_REG_STATUS 4'h4
`define COD_REG_MASK 4'h8
`define COD_REG_LAST 4'hc
`define COD_CTRL_RESET 32'h0000_0001
`define COD_CTRL_EN_BIT 0
`define COD_EV_RESERVED 0
`define COD_EV_COP_UNUSABLE 1
`define COD_EV_FP_UNIMPL 2
`define COD_EV_CMP_INVALID 3
`define COD_EV_WIDTH 4

`define COD_OP_SPECIAL 6'h00
`define COD_OP_REGIMM 6'h01
`define COD_OP_SYSTEM_COPROCESSOR 6'h10
`define COD_OP_COP1 6'h11
`define COD_OP_COP3 6'h13
`define COD_OP_MAC 6'h1c
`define COD_RS_BRANCH 5'h08

`define COD_FMT_SINGLE 5'h10
`define COD_FMT_DOUBLE 5'h11
`define COD_FMT_WORD 5'h14
`define COD_FMT_LONG 5'h15

`define COD_FN_XLATE_READ 6'h01
`define COD_FN_XLATE_WR_IDX 6'h02
`define COD_FN_XLATE_WR_RND 6'h06
`define COD_FN_XLATE_PROBE 6'h08
`define COD_FN_EXC_RETURN 6'h18
`define COD_FN_DBG_RETURN 6'h1f
`define COD_FN_WAIT 6'h20
`define COD_FN_SIGNED_MULTIPLY_ADD_S 6'h00
`define COD_FN_SIGNED_MULTIPLY_ADD_U 6'h01
`define COD_FN_CVT_S 6'h20
`define COD_FN_CVT_D 6'h21
`define COD_FN_CVT_W 6'h24
`define COD_FN_CVT_L 6'h25

`define COD_CLS_NONE 5'h00
`define COD_CLS_BR_FALSE 5'h01
`define COD_CLS_BR_TRUE 5'h02
`define COD_CLS_BR_FALSE_LIKELY 5'h03
`define COD_CLS_BR_TRUE_LIKELY 5'h04
`define COD_CLS_XLATE_READ 5'h05
`define COD_CLS_XLATE_WR_IDX 5'h06
`define COD_CLS_XLATE_WR_RND 5'h07
`define COD_CLS_XLATE_PROBE 5'h08
`define COD_CLS_EXC_RETURN 5'h09
`define COD_CLS_DBG_RETURN 5'h0a
`define COD_CLS_WAIT 5'h0b
`define COD_CLS_SIGNED_MULTIPLY_ADD_S 5'h0c
`define COD_CLS_SIGNED_MULTIPLY_ADD_U 5'h0d
`define COD_CLS_FP_OP 5'h0e
`define COD_CLS_NOP 5'h0f
`define COD_CLS_OTHER 5'h10
`define COD_CLS_COP_MOVE 5'h11

`define COD_FORM_IMM 2'h0
`define COD_FORM_REG 2'h1
`define COD_FORM_OTHER 2'h2

`endif

// *** logic/cod_decoder.v ***
// Coprocessor and secondary opcode decoder with Avalon-MM status registers
`timescale 1ns/1ns
`include "cod_defines.vh"

module cod_decoder (
    input wire mclk_in,
    input wire rst_in,
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    output wire irq_out,
    input wire instr_valid_in,
    input wire [31:0] instr_in,
    input wire kernel_mode_in,
    input wire mode64_in,
    input wire [3:0] cop_usable_in,
    input wire fcc_in,
    input wire cmp_unordered_in,
    input wire cmp_less_in,
    input wire cmp_equal_in,
    output reg dec_valid_out,
    output reg [4:0] op_class_out,
    output reg [1:0] form_out,
    output reg exc_reserved_out,
    output reg exc_cop_unusable_out,
    output reg exc_fp_unimpl_out,
    output reg branch_take_out,
    output reg cmp_result_out,
    output reg cmp_invalid_out
);

    // Reserved entries of the special function table
    function special_reserved;
        input [5:0] fn;
        begin
            case (fn)
                6'h01, 6'h05, 6'h0a, 6'h0b, 6'h15, 6'h28, 6'h29, 6'h35, 6'h37, 6'h39, 6'h3d: special_reserved = 1'b1;
                default: special_reserved = 1'b0;
            endcase
        end
    endfunction

    // Doubleword entries of the special function table
    function special_dword;
        input [5:0] fn;
        begin
            case (fn)
                6'h14, 6'h16, 6'h17, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h2c, 6'h2d, 6'h2e, 6'h2f,
                6'h38, 6'h3a, 6'h3b, 6'h3c, 6'h3e, 6'h3f: special_dword = 1'b1;
                default: special_dword = 1'b0;
            endcase
        end
    endfunction

    // Reserved entries of the primary table
    function primary_reserved;
        input [5:0] op;
        begin
            case (op)
                6'h1d, 6'h1e, 6'h1f, 6'h3b: primary_reserved = 1'b1;
                default: primary_reserved = 1'b0;
            endcase
        end
    endfunction

    // Doubleword entries of the primary table
    function primary_dword;
        input [5:0] op;
        begin
            case (op)
                6'h18, 6'h19, 6'h1a, 6'h1b, 6'h27, 6'h2c, 6'h2d, 6'h34, 6'h37, 6'h3c, 6'h3f: primary_dword = 1'b1;
                default: primary_dword = 1'b0;
            endcase
        end
    endfunction

    // Reserved entries of the register-immediate table
    function regimm_reserved;
        input [4:0] rt;
        begin
            case (rt)
                5'h00, 5'h01, 5'h02, 5'h03, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0e,
                5'h10, 5'h11, 5'h12, 5'h13: regimm_reserved = 1'b0;
                default: regimm_reserved = 1'b1;
            endcase
        end
    endfunction

    // Operation and format pair accepted by the floating-point unit
    function fp_pair_valid;
        input [5:0] fn;
        input [4:0] fmt;
        reg is_float;
        reg is_fixed;
        begin
            is_float = (fmt == `COD_FMT_SINGLE) || (fmt == `COD_FMT_DOUBLE);
            is_fixed = (fmt == `COD_FMT_WORD) || (fmt == `COD_FMT_LONG);
            fp_pair_valid = 1'b0;
            if (fn[5:4] == 2'b00) begin
                fp_pair_valid = is_float;
            end else if (fn[5:4] == 2'b11) begin
                fp_pair_valid = is_float;
            end else if (fn == `COD_FN_CVT_S) begin
                fp_pair_valid = is_fixed || (fmt == `COD_FMT_DOUBLE);
            end else if (fn == `COD_FN_CVT_D) begin
                fp_pair_valid = is_fixed || (fmt == `COD_FMT_SINGLE);
            end else if (fn == `COD_FN_CVT_W || fn == `COD_FN_CVT_L) begin
                fp_pair_valid = is_float;
            end
        end
    endfunction

    // Instruction fields
    wire [5:0] opcode = instr_in[31:26];
    wire [4:0] rs = instr_in[25:21];
    wire [4:0] rt = instr_in[20:16];
    wire [5:0] fn = instr_in[5:0];
    wire [1:0] cop_num = opcode[1:0];
    wire is_cop = (opcode[5:2] == 4'b0100);
    wire is_cop_mem = (opcode[5:4] == 2'b11) && (opcode[1:0] != 2'b00) && (opcode[1:0] != 2'b11);
    wire dword_ok = kernel_mode_in || mode64_in;

    // Registers
    reg [31:0] ctrl_reg;
    reg [`COD_EV_WIDTH-1:0] status_reg;
    reg [`COD_EV_WIDTH-1:0] status_next;
    reg [`COD_EV_WIDTH-1:0] mask_reg;
    reg rvalid_reg;

    // Combinational decode
    reg [4:0] cls_next;
    reg [1:0] form_next;
    reg resv_next;
    reg cu_next;
    reg unimpl_next;
    reg take_next;
    reg cmp_next;
    reg inv_next;
    reg is_compare;

    always @* begin
        cls_next = `COD_CLS_OTHER;
        form_next = `COD_FORM_OTHER;
        resv_next = 1'b0;
        cu_next = 1'b0;
        unimpl_next = 1'b0;
        take_next = 1'b0;
        is_compare = 1'b0;
        cmp_next = (fn[0] & cmp_unordered_in) | (fn[1] & cmp_equal_in) | (fn[2] & cmp_less_in);
        inv_next = 1'b0;
        if (opcode[5]) begin
            form_next = `COD_FORM_IMM;
        end
        if (primary_reserved(opcode)) begin
            resv_next = 1'b1;
        end else if (primary_dword(opcode) && !dword_ok) begin
            resv_next = 1'b1;
        end else if (opcode == `COD_OP_SPECIAL) begin
            resv_next = special_reserved(fn) || (special_dword(fn) && !dword_ok);
        end else if (opcode == `COD_OP_REGIMM) begin
            resv_next = regimm_reserved(rt);
        end else if (opcode == `COD_OP_MAC) begin
            case (fn)
                `COD_FN_SIGNED_MULTIPLY_ADD_S: cls_next = `COD_CLS_SIGNED_MULTIPLY_ADD_S;
                `COD_FN_SIGNED_MULTIPLY_ADD_U: cls_next = `COD_CLS_SIGNED_MULTIPLY_ADD_U;
                default: resv_next = 1'b1;
            endcase
        end else if (is_cop_mem) begin
            cu_next = !(cop_usable_in[opcode[1:0]]);
        end else if (is_cop) begin
            if (!(cop_usable_in[cop_num] || (cop_num == 2'b00 && kernel_mode_in))) begin
                cu_next = 1'b1;
            end else if (rs == `COD_RS_BRANCH) begin
                if (rt[4:3] == 2'b00 && rt[2] == 1'b0) begin
                    case (rt[1:0])
                        2'b00: cls_next = `COD_CLS_BR_FALSE;
                        2'b01: cls_next = `COD_CLS_BR_TRUE;
                        2'b10: cls_next = `COD_CLS_BR_FALSE_LIKELY;
                        default: cls_next = `COD_CLS_BR_TRUE_LIKELY;
                    endcase
                    take_next = rt[0] ? fcc_in : ~fcc_in;
                end else begin
                    resv_next = 1'b1;
                end
            end else if (opcode == `COD_OP_COP3) begin
                resv_next = 1'b1;
            end else if (rs[4]) begin
                if (opcode == `COD_OP_SYSTEM_COPROCESSOR) begin
                    case (fn)
                        `COD_FN_XLATE_READ: cls_next = `COD_CLS_XLATE_READ;
                        `COD_FN_XLATE_WR_IDX: cls_next = `COD_CLS_XLATE_WR_IDX;
                        `COD_FN_XLATE_WR_RND: cls_next = `COD_CLS_XLATE_WR_RND;
                        `COD_FN_XLATE_PROBE: cls_next = `COD_CLS_XLATE_PROBE;
                        `COD_FN_EXC_RETURN: cls_next = `COD_CLS_EXC_RETURN;
                        `COD_FN_DBG_RETURN: cls_next = `COD_CLS_DBG_RETURN;
                        `COD_FN_WAIT: cls_next = `COD_CLS_WAIT;
                        default: cls_next = `COD_CLS_NOP;
                    endcase
                end else if (opcode == `COD_OP_COP1) begin
                    cls_next = `COD_CLS_FP_OP;
                    form_next = `COD_FORM_REG;
                    unimpl_next = !fp_pair_valid(fn, rs);
                    is_compare = (fn[5:4] == 2'b11);
                    inv_next = is_compare && fn[3] && cmp_unordered_in && !unimpl_next;
                end
            end else begin
                cls_next = `COD_CLS_COP_MOVE;
                case (rs[2:0])
                    3'h3, 3'h7: resv_next = 1'b1;
                    3'h1, 3'h5: resv_next = rs[3] || !dword_ok;
                    default: resv_next = rs[3];
                endcase
            end
        end
        if (resv_next || cu_next) begin
            cls_next = `COD_CLS_NONE;
        end
    end

    // Decode results, one clock after the word
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            dec_valid_out <= 1'b0;
            op_class_out <= `COD_CLS_NONE;
            form_out <= `COD_FORM_OTHER;
            exc_reserved_out <= 1'b0;
            exc_cop_unusable_out <= 1'b0;
            exc_fp_unimpl_out <= 1'b0;
            branch_take_out <= 1'b0;
            cmp_result_out <= 1'b0;
            cmp_invalid_out <= 1'b0;
        end else if (instr_valid_in && ctrl_reg[`COD_CTRL_EN_BIT]) begin
            dec_valid_out <= 1'b1;
            op_class_out <= cls_next;
            form_out <= form_next;
            exc_reserved_out <= resv_next;
            exc_cop_unusable_out <= cu_next;
            exc_fp_unimpl_out <= unimpl_next;
            branch_take_out <= take_next;
            cmp_result_out <= is_compare & cmp_next;
            cmp_invalid_out <= inv_next;
        end else begin
            dec_valid_out <= 1'b0;
            op_class_out <= `COD_CLS_NONE;
            form_out <= `COD_FORM_OTHER;
            exc_reserved_out <= 1'b0;
            exc_cop_unusable_out <= 1'b0;
            exc_fp_unimpl_out <= 1'b0;
            branch_take_out <= 1'b0;
            cmp_result_out <= 1'b0;
            cmp_invalid_out <= 1'b0;
        end
    end

    // Bus access decode
    wire wr_ctrl = avs_write_in && (avs_address_in == `COD_REG_CTRL);
    wire wr_status = avs_write_in && (avs_address_in == `COD_REG_STATUS) && avs_byteenable_in[0];
    wire wr_mask = avs_write_in && (avs_address_in == `COD_REG_MASK) && avs_byteenable_in[0];
    wire [`COD_EV_WIDTH-1:0] events = {dec_valid_out & cmp_invalid_out, dec_valid_out & exc_fp_unimpl_out,
                                       dec_valid_out & exc_cop_unusable_out, dec_valid_out & exc_reserved_out};

    // Sticky status, set wins over clear
    always @* begin
        status_next = status_reg;
        if (wr_status) begin
            status_next = status_reg & ~avs_writedata_in[`COD_EV_WIDTH-1:0];
        end
        status_next = status_next | events;
    end

    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_reg <= `COD_CTRL_RESET;
            status_reg <= {`COD_EV_WIDTH{1'b0}};
            mask_reg <= {`COD_EV_WIDTH{1'b0}};
        end else begin
            status_reg <= status_next;
            if (wr_mask) begin
                mask_reg <= avs_writedata_in[`COD_EV_WIDTH-1:0];
            end
            if (wr_ctrl && avs_byteenable_in[0]) begin
                ctrl_reg[7:0] <= avs_writedata_in[7:0];
            end
            if (wr_ctrl && avs_byteenable_in[1]) begin
                ctrl_reg[15:8] <= avs_writedata_in[15:8];
            end
            if (wr_ctrl && avs_byteenable_in[2]) begin
                ctrl_reg[23:16] <= avs_writedata_in[23:16];
            end
            if (wr_ctrl && avs_byteenable_in[3]) begin
                ctrl_reg[31:24] <= avs_writedata_in[31:24];
            end
        end
    end

    // Reads answer one cycle late
    assign avs_waitrequest_out = avs_read_in & ~rvalid_reg;

    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rvalid_reg <= 1'b0;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            rvalid_reg <= avs_read_in & ~rvalid_reg;
            if (avs_read_in && !rvalid_reg) begin
                case (avs_address_in)
                    `COD_REG_CTRL: avs_readdata_out <= ctrl_reg;
                    `COD_REG_STATUS: avs_readdata_out <= {28'h0000000, status_reg};
                    `COD_REG_MASK: avs_readdata_out <= {28'h0000000, mask_reg};
                    `COD_REG_LAST: avs_readdata_out <= {18'h00000, op_class_out, form_out, cmp_invalid_out,
                                                        cmp_result_out, branch_take_out, exc_fp_unimpl_out,
                                                        exc_cop_unusable_out, exc_reserved_out, dec_valid_out};
                    default: avs_readdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign irq_out = |(status_reg & mask_reg);

endmodule

// *** verif/cod_decoder_chk.sv ***
// Assertion checker for the coprocessor opcode decoder
`timescale 1ns/1ns
`include "cod_defines.vh"
module cod_decoder_chk (
    input wire mclk_in,
    input wire rst_in,
    input wire instr_valid_in,
    input wire [31:0] instr_in,
    input wire kernel_mode_in,
    input wire mode64_in,
    input wire [3:0] cop_usable_in,
    input wire fcc_in,
    input wire cmp_unordered_in,
    input wire dec_valid_out,
    input wire [4:0] op_class_out,
    input wire [1:0] form_out,
    input wire exc_reserved_out,
    input wire exc_cop_unusable_out,
    input wire exc_fp_unimpl_out,
    input wire branch_take_out,
    input wire cmp_invalid_out
);
    reg [31:0] p_ins;
    reg [7:0] p_st;
    wire [5:0] p_op = p_ins[31:26];
    wire [5:0] p_fn = p_ins[5:0];
    wire p_co = dec_valid_out && p_ins[25];
    wire system_coprocessor_known = p_fn == 6'h01 || p_fn == 6'h02 || p_fn == 6'h06 || p_fn == 6'h08 ||
        p_fn == 6'h18 || p_fn == 6'h1f || p_fn == 6'h20;
    // Word and state as taken at the decode edge
    always @(posedge mclk_in) begin
        p_ins <= instr_in;
        p_st <= {cmp_unordered_in, fcc_in, cop_usable_in, mode64_in, kernel_mode_in};
    end
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    sequence s_branch;
        dec_valid_out && op_class_out >= `COD_CLS_BR_FALSE && op_class_out <= `COD_CLS_BR_TRUE_LIKELY;
    endsequence
    chk_valid_cause: assert property (dec_valid_out |-> $past(instr_valid_in))
        else $error("decode result without a word");
    chk_nop_unassigned: assert property (p_co && p_op == `COD_OP_SYSTEM_COPROCESSOR && p_st[0] && !system_coprocessor_known |->
        op_class_out == `COD_CLS_NOP && !exc_reserved_out) else $error("unassigned function not a no-op");
    chk_return_decode: assert property (p_co && p_op == `COD_OP_SYSTEM_COPROCESSOR && p_st[0] &&
        p_fn == `COD_FN_EXC_RETURN |-> op_class_out == `COD_CLS_EXC_RETURN) else $error("return not decoded");
    chk_mac_reserved: assert property (dec_valid_out && p_op == `COD_OP_MAC |->
        exc_reserved_out == (p_fn > 6'h01)) else $error("multiply-add reserved flag wrong");
    chk_cop_unusable: assert property (dec_valid_out && p_op[5:2] == 4'h4 |-> exc_cop_unusable_out ==
        !(p_st[2 + p_op[1:0]] || (p_op[1:0] == 2'h0 && p_st[0]))) else $error("unusable flag wrong");
    chk_cop3_branch_only: assert property (dec_valid_out && p_op == `COD_OP_COP3 && p_st[5] &&
        p_ins[25:21] != `COD_RS_BRANCH |-> exc_reserved_out) else $error("coprocessor 3 not reserved");
    chk_branch_take: assert property (s_branch |->
        branch_take_out == (op_class_out[0] ? !p_st[6] : p_st[6])) else $error("branch sense wrong");
    chk_cmp_invalid: assert property (cmp_invalid_out |-> dec_valid_out && p_ins[3] && p_st[7])
        else $error("invalid flag without unordered code");
    chk_double_mode: assert property (dec_valid_out && (p_op == 6'h18 || p_op == 6'h19) |->
        exc_reserved_out == !(p_st[0] || p_st[1])) else $error("doubleword mode check wrong");
    chk_imm_form: assert property (dec_valid_out && p_op[5] |-> form_out == `COD_FORM_IMM)
        else $error("immediate form wrong");
    chk_fmt_reserved: assert property (p_co && p_op == `COD_OP_COP1 && p_st[3] &&
        p_ins[25:21] == 5'h12 |-> exc_fp_unimpl_out) else $error("reserved format accepted");
endmodule

// *** verif/cod_fetch_model.sv ***
// Fetch and pipeline model presenting words and processor state
`timescale 1ns/1ns
module cod_fetch_model (
    input wire mclk_in,
    input wire rst_in,
    input wire issue_in,
    input wire [31:0] word_in,
    input wire [9:0] state_in,
    output reg instr_valid_out,
    output reg [31:0] instr_out,
    output reg [9:0] state_out
);
    // Idle cycles flip word and state each cycle: first the complement, then the last value again
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            instr_valid_out <= 1'b0;
            instr_out <= 32'h0;
            state_out <= 10'h0;
        end else begin
            instr_valid_out <= issue_in;
            instr_out <= issue_in ? word_in : ~instr_out;
            state_out <= issue_in ? state_in : ~state_out;
        end
    end
endmodule

// *** verif/cod_decoder_test.sv ***
// Self-checking testbench for the coprocessor opcode decoder
`timescale 1ns/1ns
`include "cod_defines.vh"
module cod_decoder_test;
    typedef struct {int cls; int resv; int cu; int unimp; int take; int cres; int cinv; int form;} cod_exp_t;
    logic mclk_in = 0, rst_in = 1, rd = 0, wr = 0, iss = 0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, word = 32'h0, w, r;
    logic [9:0] st = 10'h0;
    wire [31:0] rdata, instr;
    wire [9:0] pst;
    wire wait_r, irq, ivld, dv, resv, cu, unimp, take, cres, cinv;
    wire [4:0] cls;
    wire [1:0] form;
    int fails = 0, comparisons = 0, seed = 32'h8df9, ev = 0, en = 1, i, k;
    int ops[7] = '{'h10, 'h11, 'h13, 'h1c, 'h18, 'h19, 'h23};
    cod_exp_t q[$];
    cod_fetch_model FM (.mclk_in(mclk_in), .rst_in(rst_in), .issue_in(iss), .word_in(word), .state_in(st),
        .instr_valid_out(ivld), .instr_out(instr), .state_out(pst));
    cod_decoder DUT (.mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wait_r), .irq_out(irq), .instr_valid_in(ivld), .instr_in(instr),
        .kernel_mode_in(pst[0]), .mode64_in(pst[1]), .cop_usable_in(pst[5:2]), .fcc_in(pst[6]),
        .cmp_unordered_in(pst[7]), .cmp_less_in(pst[8]), .cmp_equal_in(pst[9]), .dec_valid_out(dv),
        .op_class_out(cls), .form_out(form), .exc_reserved_out(resv), .exc_cop_unusable_out(cu),
        .exc_fp_unimpl_out(unimp), .branch_take_out(take), .cmp_result_out(cres), .cmp_invalid_out(cinv));
    initial begin
        forever #2 mclk_in = ~mclk_in;
    end
    // Reference decode; state bits: eq,lt,un,fcc,usable[3:0],mode64,kernel
    function automatic cod_exp_t model(logic [31:0] wd, logic [9:0] s);
        cod_exp_t e;
        int op, rs, rt, fn;
        logic ok, sd;
        op = wd[31:26];
        rs = wd[25:21];
        rt = wd[20:16];
        fn = wd[5:0];
        e = '{-1, 0, 0, 0, -1, -1, -1, 2};
        sd = rs == 16 || rs == 17;
        if (op[5]) e.form = 0;
        else if (op == 17 && rs >= 16 && s[3]) e.form = 1;
        if (op >= 16 && op <= 19 && !s[2 + op - 16] && !(op == 16 && s[0])) e.cu = 1;
        else if (op >= 16 && op <= 19 && rs == 8) begin
            if (rt > 3) e.resv = 1;
            else begin
                e.cls = rt + 1;
                e.take = rt[0] ? s[6] : !s[6];
            end
        end else if (op == 16) e.cls = fn == 1 ? 5 : fn == 2 ? 6 : fn == 6 ? 7 : fn == 8 ? 8 :
            fn == 24 ? 9 : fn == 31 ? 10 : fn == 32 ? 11 : 15;
        else if (op == 19 || (op == 28 && fn > 1) || ((op == 24 || op == 25) && !s[0] && !s[1])) e.resv = 1;
        else if (op == 28) e.cls = 12 + fn;
        else if (op == 17) begin
            ok = (fn < 16 || fn >= 48 || fn == 36 || fn == 37) ? sd : fn == 32 ? (rs == 17 || rs == 20 || rs == 21) :
                fn == 33 ? (rs == 16 || rs == 20 || rs == 21) : 1'b0;
            e.unimp = !ok;
            if (ok) e.cls = 14;
            if (ok && fn >= 48) begin
                e.cres = (fn[0] & s[7]) | (fn[1] & s[9]) | (fn[2] & s[8]);
                e.cinv = fn[3] & s[7];
            end
        end else e.cls = 16;
        return e;
    endfunction
    task results;
        if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task bad(string m);
        fails++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task chk_field(string m, logic [31:0] got, int exp);
        if (exp >= 0) begin
            comparisons++;
            if (got !== exp) bad(m);
        end
    endtask
    task chk_dec(cod_exp_t e);
        chk_field("class", cls, e.cls);
        chk_field("reserved", resv, e.resv);
        chk_field("unusable", cu, e.cu);
        chk_field("unimplemented", unimp, e.unimp);
        chk_field("take", take, e.take);
        chk_field("compare", cres, e.cres);
        chk_field("invalid", cinv, e.cinv);
        chk_field("form", form, e.form);
    endtask
    always @(negedge mclk_in) begin
        if (!rst_in && dv !== 1'b0) begin
            if (q.size() == 0) bad("decode result with no word");
            else chk_dec(q.pop_front());
        end
    end
    task bus(logic wr_n, logic [3:0] a, logic [31:0] d);
        rd <= !wr_n;
        wr <= wr_n;
        adr <= a;
        wdat <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge mclk_in);
            if (wait_r === 1'b0) break;
        end
        if (k == 20) begin
            bad("bus timeout");
            results();
        end
        rdat = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge mclk_in);
    endtask
    task issue(logic [31:0] wd, logic [9:0] s);
        cod_exp_t e;
        iss <= 1'b1;
        word <= wd;
        st <= s;
        e = model(wd, s);
        if (en) begin
            q.push_back(e);
            ev = ev | {e.cinv == 1, e.unimp == 1, e.cu == 1, e.resv == 1};
        end
        @(posedge mclk_in);
    endtask
    task idle(int n);
        iss <= 1'b0;
        repeat (n) @(posedge mclk_in);
    endtask
    initial begin
        repeat (12) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        bus(0, 4'h0, 0);
        chk_field("ctrl reset", rdat, 1);
        bus(0, 4'h2, 0);
        chk_field("unmapped read", rdat, 0);
        bus(1, 4'h8, 0);
        for (i = 0; i < 64; i++) issue({6'h10, 1'b1, 19'h0, i[5:0]}, 10'h001);
        for (i = 0; i < 64; i++) issue({6'h1c, 20'h0, i[5:0]}, 10'h000);
        for (i = 0; i < 32; i++) issue({6'h11, 5'h08, i[4:0], 16'h0}, {3'h0, i[1] ^ i[2], 6'h3d});
        for (i = 0; i < 64; i++) begin
            r = $random(seed);
            issue({6'h11, 4'h8, i[4], 15'h0, 2'h3, i[3:0]}, {r[2:0], 7'h3d});
        end
        for (i = 0; i < 400; i++) begin
            r = $random(seed);
            w = $random(seed);
            w[31:26] = 6'(ops[r[2:0] % 7]);
            if (r[3]) w[25:21] = 5'h08;
            else if (r[4]) w[25:21] = {2'h2, r[5], 1'b0, r[6]};
            else w[25] = 1'b1;
            issue(w, r[9] ? {r[15:12], 4'hf, r[11:10]} : r[19:10]);
        end
        idle(4);
        bus(0, 4'h4, 0);
        chk_field("status", rdat, ev);
        chk_field("irq masked", irq, 0);
        bus(1, 4'h8, 32'hf);
        chk_field("irq unmasked", irq, ev != 0);
        bus(1, 4'h4, 32'hf);
        bus(0, 4'h4, 0);
        chk_field("status cleared", rdat, 0);
        chk_field("irq cleared", irq, 0);
        bus(1, 4'h0, 0);
        en = 0;
        for (i = 0; i < 4; i++) issue({6'h10, 1'b1, 19'h0, 6'h18}, 10'h001);
        idle(4);
        en = 1;
        bus(1, 4'h0, 1);
        issue({6'h10, 1'b1, 19'h0, 6'h18}, 10'h001);
        idle(4);
        if (q.size() != 0) bad("missing decode results");
        results();
    end
endmodule
bind cod_decoder cod_decoder_chk CHK (.mclk_in(mclk_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .kernel_mode_in(kernel_mode_in), .mode64_in(mode64_in), .cop_usable_in(cop_usable_in),
    .fcc_in(fcc_in), .cmp_unordered_in(cmp_unordered_in), .dec_valid_out(dec_valid_out),
    .op_class_out(op_class_out), .form_out(form_out), .exc_reserved_out(exc_reserved_out),
    .exc_cop_unusable_out(exc_cop_unusable_out), .exc_fp_unimpl_out(exc_fp_unimpl_out),
    .branch_take_out(branch_take_out), .cmp_invalid_out(cmp_invalid_out));
